// ===== design/bcd_ctrl.sv
// Blink code diagnostic controller: switch sequences, lamp and fault table.
`timescale 1ns/10ps
// Notes on behaviour
// - Switch ignored for 2 s after power-up, except for reconfiguration.
// - A press counts if held at least 0.1 s and released before 5 s.
// - Holding over five seconds flags a switch fault; the press is dropped.
// - After 3.5 s of idle switch the sequence closes; the response starts.
// - Blinks are half a second on, with half-second off gaps inside a digit.
// - Lamp stays off 1.5 s between digits.
// - Lamp stays off 2.5 s between messages.
// - Lamp stays on five seconds after the final message.
// - A started display shows all messages and ignores the switch.
// - No diagnostics while wheels move; motion aborts a running display.
// - A fault lights the lamp, disables functions, is stored and reported.
// - Faults other than voltage and network stay active for the power cycle.
// - Voltage faults self-clear when supply is good; braking comes back.
// - Network faults self-clear when communication returns.
// - One press shows active faults, two digits per fault message.
// - Two presses show every inactive fault from history.
// - Three presses clear active faults, or just exit when dyno mode is on.
// - Power cycle clears codes; carried wheel codes need valid wheel speeds.
// - Every cleared active code is written to history.
// - Dyno mode turns traction off, survives power, changes only by tool.
// - Reconfigure: switch held at power-up, released, then seven presses.
// - Four presses show the six configuration digits.
module bcd_ctrl #(
    parameter int TICK_CYCLES = bcd_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic               CLK,
    input  wire logic               RSTN,
    // Pins.
    input  wire logic               SWITCH_CLOSED,
    input  wire logic               WHEEL_MOTION,
    // Vehicle status from internal logic.
    input  wire logic               WHEEL_SPEED_VALID,
    input  wire logic               VOLT_OK,
    input  wire logic               NET_OK,
    input  wire logic               FAULT_SET,
    input  wire bcd_pkg::bcd_fault_t FAULT,
    // Nonvolatile settings and tool commands.
    input  wire logic               NV_DYNO,
    input  wire logic               NV_WSS_VALID,
    input  wire bcd_pkg::bcd_fault_t NV_WSS,
    input  wire logic               TOOL_DYNO_SET,
    input  wire logic               TOOL_DYNO_CLR,
    // Outputs.
    output logic                    LAMP,
    output logic                    BRAKE_DISABLE,
    output logic                    TRACTION_OFF,
    output logic                    SWITCH_FAULT,
    output logic                    RECONFIG,
    output logic                    DIAG_ACTIVE,
    output logic                    DYNO_STORE,
    output logic                    REPORT_VALID,
    output bcd_pkg::bcd_fault_t     REPORT
);
    import bcd_pkg::*;

    bcd_state_t st;
    bcd_state_t next_st;
    logic       tmo;
    logic [5:0] lim;

    function automatic logic [NSLOT-1:0] vmask(input bcd_tab_t t);
        logic [NSLOT-1:0] m;
        m = '0;
        for (int i = 0; i < NSLOT; i++) begin
            m[i] = t[i].valid;
        end
        return m;
    endfunction

    function automatic logic [3:0] next_valid(input logic [NSLOT-1:0] m,
                                              input logic [3:0] from);
        logic [3:0] r;
        r = '0;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (m[i] && 4'(i) >= from) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] digit_of(input logic cfg,
                                            input logic found,
                                            input bcd_dtc_t e,
                                            input logic [2:0] dig);
        logic [3:0] d;
        if (cfg) begin
            d = CFG_DIGITS[dig];
        end else if (!found) begin
            d = NOFAULT_D;
        end else begin
            d = (dig == 3'h0) ? e.f.d1 : e.f.d0;
        end
        return d;
    endfunction

    // -----------------------------------------------------------------
    // Timer limit of the current step.
    // -----------------------------------------------------------------
    always_comb begin
        lim = BOOT_T;
        unique case (st.main)
            S_PRESS: lim = PMAX_T;
            S_GAP:   lim = IDLE_T;
            S_SHOW: begin
                unique case (st.disp)
                    D_ON, D_GAP: lim = BLINK_T;
                    D_DGAP:      lim = DGAP_T;
                    D_MGAP:      lim = MGAP_T;
                    D_FINAL:     lim = FINAL_T;
                endcase
            end
            S_BOOT, S_IDLE, S_STUCK: lim = BOOT_T;
        endcase
        tmo = st.tick && (st.tcnt == lim - 6'h1);
    end

    // -----------------------------------------------------------------
    // Next state.
    // -----------------------------------------------------------------
    always_comb begin
        logic [NSLOT-1:0] m;
        logic [3:0]       r;
        logic [2:0]       nd;
        logic             clr_all;
        logic             dup;
        logic             done;
        m = '0;
        r = '0;
        nd = FAULT_ND;
        clr_all = 1'b0;
        dup = 1'b0;
        done = 1'b0;
        next_st = st;
        next_st.s1 = SWITCH_CLOSED;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.sw = st.s3;
        end
        next_st.m1 = WHEEL_MOTION;
        next_st.m2 = st.m1;
        next_st.m3 = st.m2;
        if (st.m2 == st.m3) begin
            next_st.mov = st.m3;
        end
        next_st.tick = 1'b0;
        if (st.tdiv == 32'(TICK_CYCLES - 1)) begin
            next_st.tdiv = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tdiv = st.tdiv + 32'h1;
        end
        if (st.tick) begin
            next_st.tcnt = st.tcnt + 6'h1;
        end
        next_st.recfg = 1'b0;
        next_st.rep_v = 1'b0;
        if (!st.booted) begin
            next_st.booted = 1'b1;
            next_st.dyno = NV_DYNO;
            if (NV_WSS_VALID) begin
                next_st.act[0] = {1'b1, 1'b1, NV_WSS};
            end
        end
        if (TOOL_DYNO_SET) begin
            next_st.dyno = 1'b1;
        end else if (TOOL_DYNO_CLR) begin
            next_st.dyno = 1'b0;
        end
        m = st.inact ? vmask(st.hist) : vmask(st.act);
        nd = st.cfg ? CFG_ND : FAULT_ND;
        unique case (st.main)
            S_BOOT: begin
                if (st.tick && st.tcnt == 6'h0) begin
                    next_st.armed = st.sw;
                end else if (st.armed && !st.sw) begin
                    next_st.main = S_IDLE;
                end else if (!st.armed && tmo) begin
                    next_st.main = S_IDLE;
                end
            end
            S_IDLE: begin
                next_st.tcnt = '0;
                if (st.sw) begin
                    next_st.main = S_PRESS;
                end
            end
            S_PRESS: begin
                if (!st.sw) begin
                    if (st.tcnt >= PMIN_T && st.pcnt != P_MAX) begin
                        next_st.pcnt = st.pcnt + 4'h1;
                    end
                    next_st.main = S_GAP;
                    next_st.tcnt = '0;
                end else if (tmo) begin
                    next_st.main = S_STUCK;
                    next_st.swf = 1'b1;
                end
            end
            S_STUCK: begin
                if (!st.sw) begin
                    next_st.main = S_GAP;
                    next_st.tcnt = '0;
                end
            end
            S_GAP: begin
                if (st.sw) begin
                    next_st.main = S_PRESS;
                    next_st.tcnt = '0;
                end else if (tmo) begin
                    next_st.main = S_IDLE;
                    next_st.pcnt = '0;
                    next_st.armed = 1'b0;
                    next_st.inact = (st.pcnt == P_INACTIVE);
                    next_st.cfg = (st.pcnt == P_CONFIG);
                    if (!st.mov) begin
                        if (st.armed && st.pcnt == P_RECFG) begin
                            next_st.recfg = 1'b1;
                        end else if (st.pcnt == P_CLEAR) begin
                            clr_all = !st.dyno;
                        end else if (st.pcnt == P_ACTIVE ||
                                     st.pcnt == P_INACTIVE ||
                                     st.pcnt == P_CONFIG) begin
                            m = (st.pcnt == P_INACTIVE) ? vmask(st.hist)
                                                        : vmask(st.act);
                            r = next_valid(m, 4'h0);
                            next_st.found = r[3];
                            next_st.slot = r[2:0];
                            next_st.digit = '0;
                            next_st.blinks = digit_of(next_st.cfg, r[3],
                                next_st.inact ? st.hist[r[2:0]]
                                              : st.act[r[2:0]], 3'h0);
                            next_st.main = S_SHOW;
                            next_st.disp = D_ON;
                            next_st.lamp = 1'b1;
                            next_st.tcnt = '0;
                        end
                    end
                end
            end
            S_SHOW: begin
                if (st.mov) begin
                    next_st.main = S_IDLE;
                end else if (tmo) begin
                    next_st.tcnt = '0;
                    unique case (st.disp)
                        D_ON: begin
                            next_st.lamp = 1'b0;
                            if (st.blinks > 4'h1) begin
                                next_st.blinks = st.blinks - 4'h1;
                                next_st.disp = D_GAP;
                            end else if (st.digit < nd - 3'h1) begin
                                next_st.disp = D_DGAP;
                            end else begin
                                next_st.disp = D_MGAP;
                            end
                        end
                        D_GAP: begin
                            next_st.lamp = 1'b1;
                            next_st.disp = D_ON;
                        end
                        D_DGAP: begin
                            next_st.digit = st.digit + 3'h1;
                            next_st.blinks = digit_of(st.cfg, st.found,
                                st.inact ? st.hist[st.slot]
                                         : st.act[st.slot],
                                st.digit + 3'h1);
                            next_st.lamp = 1'b1;
                            next_st.disp = D_ON;
                        end
                        D_MGAP: begin
                            r = next_valid(m, {1'b0, st.slot} + 4'h1);
                            next_st.lamp = 1'b1;
                            if (st.found && !st.cfg && r[3]) begin
                                next_st.slot = r[2:0];
                                next_st.digit = '0;
                                next_st.blinks = digit_of(1'b0, 1'b1,
                                    st.inact ? st.hist[r[2:0]]
                                             : st.act[r[2:0]], 3'h0);
                                next_st.disp = D_ON;
                            end else begin
                                next_st.disp = D_FINAL;
                            end
                        end
                        D_FINAL: begin
                            next_st.main = S_IDLE;
                            done = 1'b1;
                        end
                    endcase
                end
            end
        endcase
        for (int i = 0; i < NSLOT; i++) begin
            if (next_st.act[i].valid &&
                (clr_all ||
                 (next_st.act[i].f.kind == K_VOLT && VOLT_OK) ||
                 (next_st.act[i].f.kind == K_NET && NET_OK) ||
                 (next_st.act[i].held && WHEEL_SPEED_VALID))) begin
                next_st.hist[next_st.hptr] = {1'b1, 1'b0, next_st.act[i].f};
                next_st.hptr = next_st.hptr + 3'h1;
                next_st.act[i].valid = 1'b0;
            end
        end
        if (FAULT_SET) begin
            for (int i = 0; i < NSLOT; i++) begin
                if (next_st.act[i].valid && next_st.act[i].f == FAULT) begin
                    dup = 1'b1;
                end
            end
            r = next_valid(~vmask(next_st.act), 4'h0);
            if (!dup && r[3]) begin
                next_st.act[r[2:0]] = {1'b1, 1'b0, FAULT};
                next_st.rep_v = 1'b1;
                next_st.rep = FAULT;
            end
        end
        next_st.brk = |vmask(next_st.act);
        if (next_st.main != S_SHOW || done) begin
            next_st.lamp = next_st.brk;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign LAMP = st.lamp;
    assign BRAKE_DISABLE = st.brk;
    assign TRACTION_OFF = st.brk | st.dyno;
    assign SWITCH_FAULT = st.swf;
    assign RECONFIG = st.recfg;
    assign DIAG_ACTIVE = (st.main == S_SHOW);
    assign DYNO_STORE = st.dyno;
    assign REPORT_VALID = st.rep_v;
    assign REPORT = st.rep;

    // -----------------------------------------------------------------
    // Checks.
    // -----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence s_press_end;
        st.main == S_PRESS && !st.sw;
    endsequence
    sequence s_gap_expire;
        st.main == S_GAP && !st.sw && tmo;
    endsequence

    chk_boot_quiet: assert property (
        st.main == S_BOOT |-> st.pcnt == 4'h0)
        else $error("press counted during power-up wait");
    chk_short_press: assert property (
        s_press_end ##0 (st.tcnt < PMIN_T) |=> st.pcnt == $past(st.pcnt))
        else $error("short press was counted");
    chk_valid_press: assert property (
        s_press_end ##0 (st.tcnt >= PMIN_T && st.pcnt != P_MAX)
        |=> st.pcnt == $past(st.pcnt) + 4'h1)
        else $error("valid press not counted");
    chk_stuck_fault: assert property (
        st.main == S_PRESS && st.sw && tmo
        |=> st.main == S_STUCK && SWITCH_FAULT && $stable(st.pcnt))
        else $error("long hold not flagged");
    chk_seq_close: assert property (
        s_gap_expire |=> st.main != S_GAP && st.pcnt == 4'h0)
        else $error("sequence did not close");
    chk_blink_len: assert property (
        st.main == S_SHOW && st.disp == D_ON && tmo && !st.mov |=> !LAMP)
        else $error("blink not ended on time");
    chk_show_holds: assert property (
        st.main == S_SHOW && !st.mov && !(st.disp == D_FINAL && tmo)
        |=> st.main == S_SHOW)
        else $error("display left early");
    chk_final_on: assert property (
        st.main == S_SHOW && st.disp == D_FINAL |-> LAMP)
        else $error("lamp off during final hold");
    chk_motion_exit: assert property (
        st.main == S_SHOW && st.mov |=> st.main == S_IDLE ##1 !DIAG_ACTIVE)
        else $error("motion did not end display");
    chk_dyno_atc: assert property (st.dyno |-> TRACTION_OFF)
        else $error("traction on in dyno mode");
endmodule

// ===== design/bcd_pkg.sv
// Constants, types and state layout of the blink code diagnostic controller.
package bcd_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_MS       = 100;
    localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;

    localparam int BOOT_MS      = 2000;
    localparam int PRESS_MIN_MS = 100;
    localparam int PRESS_MAX_MS = 5000;
    localparam int IDLE_MS      = 3500;
    localparam int BLINK_MS     = 500;
    localparam int DGAP_MS      = 1500;
    localparam int MGAP_MS      = 2500;
    localparam int FINAL_MS     = 5000;

    localparam logic [5:0] BOOT_T  = 6'((BOOT_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [5:0] PMIN_T  = 6'((PRESS_MIN_MS + TICK_MS - 1)
                                        / TICK_MS);
    localparam logic [5:0] PMAX_T  = 6'(PRESS_MAX_MS / TICK_MS);
    localparam logic [5:0] IDLE_T  = 6'((IDLE_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [5:0] BLINK_T = 6'(BLINK_MS / TICK_MS);
    localparam logic [5:0] DGAP_T  = 6'(DGAP_MS / TICK_MS);
    localparam logic [5:0] MGAP_T  = 6'(MGAP_MS / TICK_MS);
    localparam logic [5:0] FINAL_T = 6'(FINAL_MS / TICK_MS);

    localparam int NSLOT = 8;
    localparam logic [3:0] P_ACTIVE   = 4'h1;
    localparam logic [3:0] P_INACTIVE = 4'h2;
    localparam logic [3:0] P_CLEAR    = 4'h3;
    localparam logic [3:0] P_CONFIG   = 4'h4;
    localparam logic [3:0] P_RECFG    = 4'h7;
    localparam logic [3:0] P_MAX      = 4'hf;
    localparam logic [3:0] NOFAULT_D  = 4'h1;
    localparam logic [2:0] FAULT_ND   = 3'h2;
    localparam logic [2:0] CFG_ND     = 3'h6;
    localparam logic [5:0][3:0] CFG_DIGITS =
        {4'h1, 4'h5, 4'h1, 4'h6, 4'h6, 4'h2};

    typedef enum logic [1:0] {K_OTHER, K_VOLT, K_NET, K_WHEEL} bcd_kind_t;
    typedef enum logic [2:0] {
        S_BOOT, S_IDLE, S_PRESS, S_GAP, S_STUCK, S_SHOW
    } bcd_main_t;
    typedef enum logic [2:0] {
        D_ON, D_GAP, D_DGAP, D_MGAP, D_FINAL
    } bcd_disp_t;

    typedef struct packed {
        logic [3:0] d1;
        logic [3:0] d0;
        bcd_kind_t  kind;
    } bcd_fault_t;

    typedef struct packed {
        logic       valid;
        logic       held;
        bcd_fault_t f;
    } bcd_dtc_t;

    typedef bcd_dtc_t [NSLOT-1:0] bcd_tab_t;

    typedef struct packed {
        logic       s1, s2, s3, sw;
        logic       m1, m2, m3, mov;
        logic [31:0] tdiv;
        logic       tick;
        bcd_main_t  main;
        bcd_disp_t  disp;
        logic [5:0] tcnt;
        logic [3:0] pcnt;
        logic       armed, booted, inact, cfg, found;
        logic [2:0] slot, digit;
        logic [3:0] blinks;
        bcd_tab_t   act, hist;
        logic [2:0] hptr;
        logic       dyno, lamp, brk, swf, recfg, rep_v;
        bcd_fault_t rep;
    } bcd_state_t;
endpackage

// ===== sim/bcd_tech.sv
// Technician model that works the diagnostic push switch.
`timescale 1ns/10ps
module bcd_tech #(
    parameter int TICK = 10
) (
    // Clock.
    input  wire logic CLK,
    // Switch pin, high while closed.
    output logic      SWITCH_CLOSED
);
    initial SWITCH_CLOSED = 1'h0;

    // -------------------------------------------------------------------
    // Press sequence: n presses of hold ticks, gap ticks apart.
    // -------------------------------------------------------------------
    task automatic press_seq(input int n, input int hold, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge CLK) SWITCH_CLOSED <= 1'h1;
            repeat (hold * TICK) @(posedge CLK);
            SWITCH_CLOSED <= 1'h0;
            if (i < n - 1)
                repeat (gap * TICK) @(posedge CLK);
        end
    endtask
endmodule

// ===== sim/blink_code_diagnostics_bench.sv
// Self-checking bench for the blink code diagnostic controller.
`timescale 1ns/10ps
module blink_code_diagnostics_bench;
    import bcd_pkg::*;
    localparam int TK = 10;
    logic       CLK = 1'h0, RSTN = 1'h0, SWITCH_CLOSED;
    logic       WHEEL_MOTION = 1'h0, VOLT_OK = 1'h1, NET_OK = 1'h1;
    logic       FAULT_SET = 1'h0, TOOL_DYNO_SET = 1'h0, TOOL_DYNO_CLR = 1'h0;
    bcd_fault_t FAULT = '0, REPORT, NV_WSS = '{4'h2, 4'h4, K_WHEEL};
    logic       WHEEL_SPEED_VALID = 1'h1, NV_DYNO = 1'h0, NV_WSS_VALID = 1'h0;
    logic       LAMP, BRAKE_DISABLE, TRACTION_OFF, SWITCH_FAULT, RECONFIG;
    logic       DIAG_ACTIVE, DYNO_STORE, REPORT_VALID;
    int         err_total = 0, num_checks = 0, cyc = 0;
    int         exp_q[$];

    bcd_ctrl #(.TICK_CYCLES(TK)) bcd_ctrl_i (
        .CLK(CLK), .RSTN(RSTN), .SWITCH_CLOSED(SWITCH_CLOSED),
        .WHEEL_MOTION(WHEEL_MOTION),
        .WHEEL_SPEED_VALID(WHEEL_SPEED_VALID),
        .VOLT_OK(VOLT_OK), .NET_OK(NET_OK), .FAULT_SET(FAULT_SET),
        .FAULT(FAULT), .NV_DYNO(NV_DYNO), .NV_WSS_VALID(NV_WSS_VALID),
        .NV_WSS(NV_WSS),
        .TOOL_DYNO_SET(TOOL_DYNO_SET), .TOOL_DYNO_CLR(TOOL_DYNO_CLR),
        .LAMP(LAMP), .BRAKE_DISABLE(BRAKE_DISABLE),
        .TRACTION_OFF(TRACTION_OFF), .SWITCH_FAULT(SWITCH_FAULT),
        .RECONFIG(RECONFIG), .DIAG_ACTIVE(DIAG_ACTIVE),
        .DYNO_STORE(DYNO_STORE), .REPORT_VALID(REPORT_VALID),
        .REPORT(REPORT));
    bcd_tech #(.TICK(TK)) bcd_tech_i (.CLK(CLK),
        .SWITCH_CLOSED(SWITCH_CLOSED));

    always #2 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            end_sim();
        end
    end

    // -------------------------------------------------------------------
    // Reporting.
    // -------------------------------------------------------------------
    task automatic end_sim();
        if (err_total == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_near(input string nm, input int e, input int g);
        num_checks++;
        if (g < e - TK - 5 || g > e + TK + 5) begin
            err_total++;
            $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
        end
    endtask

    // -------------------------------------------------------------------
    // Scenarios.
    // -------------------------------------------------------------------
    task automatic fault_in(input logic [3:0] a, input logic [3:0] b,
                            input bcd_kind_t k);
        @(posedge CLK);
        FAULT <= '{a, b, k};
        FAULT_SET <= 1'h1;
        @(posedge CLK) FAULT_SET <= 1'h0;
        @(negedge CLK);
        chk_val("report valid", 1, REPORT_VALID);
        chk_val("report", {a, b, k}, REPORT);
        chk_val("brake disable", 1, BRAKE_DISABLE);
        chk_val("traction off", 1, TRACTION_OFF);
        chk_val("fault lamp", 1, LAMP);
    endtask
    task automatic quiet(input int t);
        int bad = 0;
        repeat (t * TK) begin
            @(negedge CLK);
            if (DIAG_ACTIVE !== 1'h0)
                bad++;
        end
        chk_val("display refused", 0, bad);
    endtask
    task automatic show(input int n, input int d[$]);
        int t = 0, k = 0, run = 0;
        logic lv = 1'h1;
        exp_q = {};
        foreach (d[i]) begin
            for (int b = 1; b < 2 * d[i]; b++)
                exp_q.push_back(int'(BLINK_T));
            exp_q.push_back(i + 1 < d.size() ? int'(DGAP_T) : int'(MGAP_T));
        end
        exp_q.push_back(int'(FINAL_T));
        bcd_tech_i.press_seq(n, 2, 10);
        while (DIAG_ACTIVE !== 1'h1 && t < 1000) begin
            @(negedge CLK);
            t++;
        end
        chk_near("close delay", int'(IDLE_T) * TK, t);
        fork
            bcd_tech_i.press_seq(1, 2, 0);
        join_none
        while (DIAG_ACTIVE === 1'h1 && k < exp_q.size()) begin
            if (LAMP === lv)
                run++;
            else begin
                chk_near("lamp run", exp_q[k] * TK, run);
                k++;
                lv = ~lv;
                run = 1;
            end
            @(negedge CLK);
        end
        chk_near("final on", exp_q[k] * TK, run);
        chk_val("run count", exp_q.size() - 1, k);
        quiet(45);
    endtask

    task automatic power_cycle();
        int seen = 0;
        @(posedge CLK) RSTN <= 1'h0;
        NV_DYNO <= 1'h1;
        NV_WSS_VALID <= 1'h1;
        WHEEL_SPEED_VALID <= 1'h0;
        fork
            bcd_tech_i.press_seq(1, 3, 0);
        join_none
        repeat (5) @(posedge CLK);
        RSTN <= 1'h1;
        repeat (40) @(negedge CLK);
        chk_val("dyno kept", 1, DYNO_STORE);
        chk_val("wheel code kept", 1, BRAKE_DISABLE);
        bcd_tech_i.press_seq(7, 2, 10);
        repeat (500) begin
            @(negedge CLK);
            if (RECONFIG === 1'h1)
                seen++;
        end
        chk_val("reconfig", 1, seen);
        @(posedge CLK) WHEEL_SPEED_VALID <= 1'h1;
        repeat (10) @(negedge CLK);
        chk_val("wheel code clear", 0, BRAKE_DISABLE);
        fault_in(4'h2, 4'h3, K_OTHER);
        bcd_tech_i.press_seq(3, 2, 10);
        quiet(45);
        chk_val("dyno no clear", 1, BRAKE_DISABLE);
    endtask

    initial begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'h1;
        @(negedge CLK);
        chk_val("reset lamp", 0, LAMP);
        repeat (5 * TK) @(posedge CLK);
        bcd_tech_i.press_seq(1, 2, 0);
        quiet(45);
        @(posedge CLK) TOOL_DYNO_SET <= 1'h1;
        @(posedge CLK) TOOL_DYNO_SET <= 1'h0;
        @(negedge CLK);
        chk_val("dyno store", 1, DYNO_STORE);
        chk_val("dyno traction", 1, TRACTION_OFF);
        @(posedge CLK) TOOL_DYNO_CLR <= 1'h1;
        @(posedge CLK) TOOL_DYNO_CLR <= 1'h0;
        @(negedge CLK);
        chk_val("dyno store", 0, DYNO_STORE);
        fault_in(4'h2, 4'h3, K_OTHER);
        show(1, '{2, 3});
        bcd_tech_i.press_seq(5, 2, 10);
        quiet(45);
        bcd_tech_i.press_seq(3, 2, 10);
        quiet(45);
        chk_val("cleared", 0, BRAKE_DISABLE);
        show(2, '{2, 3});
        show(4, '{2, 6, 6, 1, 5, 1});
        show(1, '{1, 1});
        bcd_tech_i.press_seq(1, 55, 0);
        chk_val("switch fault", 1, SWITCH_FAULT);
        quiet(45);
        bcd_tech_i.press_seq(1, 2, 0);
        repeat (40 * TK) @(negedge CLK);
        chk_val("display on", 1, DIAG_ACTIVE);
        @(posedge CLK) WHEEL_MOTION <= 1'h1;
        repeat (10) @(negedge CLK);
        chk_val("display abort", 0, DIAG_ACTIVE);
        bcd_tech_i.press_seq(1, 2, 0);
        quiet(45);
        @(posedge CLK) WHEEL_MOTION <= 1'h0;
        for (int i = 0; i < 2; i++) begin
            @(posedge CLK) {VOLT_OK, NET_OK} <= 2'h0;
            fault_in(4'h6, 4'h1 + 4'(i), i ? K_NET : K_VOLT);
            @(posedge CLK) {VOLT_OK, NET_OK} <= 2'h3;
            repeat (10) @(negedge CLK);
            chk_val("self clear", 0, BRAKE_DISABLE);
        end
        fault_in(4'h2, 4'h3, K_OTHER);
        @(posedge CLK) {VOLT_OK, NET_OK} <= 2'h0;
        @(posedge CLK) {VOLT_OK, NET_OK} <= 2'h3;
        repeat (10) @(negedge CLK);
        chk_val("fault held", 1, BRAKE_DISABLE);
        power_cycle();
        end_sim();
    end
endmodule
